/* src/idle_timer.sv */
// Saturating duration timer: reports when its run condition has held for
// LIMIT consecutive clocks.
// Assumes run_i is synchronous to clk_i; any low cycle restarts the count.
`timescale 1ns/1ps

module idle_timer #(
    parameter int LIMIT = 25
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic hit_o
);
    localparam int W = $clog2(LIMIT + 1);

    logic [W-1:0] cnt_r;

    if (LIMIT < 1)
    begin : g_chk
        $error("idle_timer: LIMIT must be at least one");
    end

    // The count sticks at LIMIT so a long idle never wraps into a false restart.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            cnt_r <= '0;
        end
        else if (cnt_r != W'(LIMIT))
        begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    assign hit_o = (cnt_r == W'(LIMIT));

endmodule : idle_timer

/* src/usb_susp_consts.svh */
// Offsets, field positions, reset values and timing counts of the suspend,
// reset and wakeup controller.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
`ifndef USB_SUSP_CONSTS_SVH
`define USB_SUSP_CONSTS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define SUSP_IDLE_MS 3
`define WAKE_IDLE_MS 5
`define SE0_RESET_NS 2500
`define WAKE_DRIVE_MS 2
`define SUSP_IDLE_CYC ((`SUSP_IDLE_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_IDLE_CYC ((`WAKE_IDLE_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SE0_RESET_CYC ((`SE0_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_DRIVE_CYC ((`WAKE_DRIVE_MS * 1000000) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define ADR_SYS_CTRL 8'h00
`define ADR_DEV_STATE 8'h04
`define ADR_IRQ_MASK 8'h08
`define ADR_IRQ_FLAGS 8'h0c

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define SYSCTL_SOFT_RST 0
`define SYSCTL_OSC_STOP 1
`define DEVST_OSC_RUN 0
`define DEVST_WAKE_REQ 4
`define DEVST_BUS_RST 5
`define DEVST_SUSP 6
`define IRQ_BUS_RST 5
`define IRQ_SUSP 6
`define IRQ_MASK_RST 8'h01

`endif

/* src/usb_susp_ctrl.sv */
// Suspend, system reset, resume detection and remote wakeup controller.
// Assumes a 10 MHz clock, line inputs synchronous to it, and a classic
// Wishbone master with 32-bit data.
`timescale 1ns/1ps
`include "usb_susp_consts.svh"

module usb_susp_ctrl
    import usb_susp_pkg::*;
#(
    parameter int SUSP_IDLE_CYC = `SUSP_IDLE_CYC,
    parameter int WAKE_IDLE_CYC = `WAKE_IDLE_CYC,
    parameter int WAKE_DRIVE_CYC = `WAKE_DRIVE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic dp_i,
    input wire logic dm_i,
    output logic dp_o,
    output logic dm_o,
    output logic d_oe_o,
    input wire logic [7:0] ext_event_i,
    output logic irq_o,
    output logic suspend_o,
    output logic osc_run_o,
    output logic sys_rst_o
);
    localparam int DRV_W = $clog2(WAKE_DRIVE_CYC + 1);

    if (SUSP_IDLE_CYC < 2 || WAKE_IDLE_CYC < SUSP_IDLE_CYC || WAKE_DRIVE_CYC < 2)
    begin : g_chk
        $error("usb_susp_ctrl: timing parameters out of range");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic soft_rst_r;
    logic sysrst;
    logic osc_run_r;
    logic suspended_r;
    logic wake_req_r;
    logic bus_rst_st_r;
    logic [7:0] mask_r;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    wake_state_t wk_state_r;
    logic [DRV_W-1:0] drv_cnt_r;
    logic line_j;
    logic line_k;
    logic line_se0;
    logic idle3_hit;
    logic idle5_hit;
    logic se0_hit;
    logic se0_hit_q;
    logic se0_rise;
    logic susp_enter;
    logic resume_det;
    logic susp_exit;
    logic bus_req;
    logic wr_en;
    logic [7:0] wbyte;

    // ------------------------------------------------------------------
    // System reset
    // ------------------------------------------------------------------
    assign sysrst = rst_i || soft_rst_r;

    // The soft reset pulse only answers to the pin, so it cannot cut itself short.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            soft_rst_r <= 1'b0;
        end
        else
        begin
            soft_rst_r <= wr_en && wb_adr_i == `ADR_SYS_CTRL && wbyte[`SYSCTL_SOFT_RST];
        end
    end

    always_ff @(posedge clk_i)
    begin
        sys_rst_o <= sysrst;
    end

    always_ff @(posedge clk_i)
    begin
        if (sysrst)
        begin
            osc_run_r <= 1'b1;
        end
        else if (wr_en && wb_adr_i == `ADR_SYS_CTRL && wbyte[`SYSCTL_OSC_STOP])
        begin
            osc_run_r <= 1'b0;
        end
    end

    assign osc_run_o = osc_run_r;

    // ------------------------------------------------------------------
    // Bus line timing
    // ------------------------------------------------------------------
    assign line_j = dp_i && !dm_i;
    assign line_k = !dp_i && dm_i;
    assign line_se0 = !dp_i && !dm_i;

    idle_timer #(.LIMIT(SUSP_IDLE_CYC)) u_idle3 (
        .clk_i(clk_i),
        .rst_i(sysrst),
        .run_i(line_j),
        .hit_o(idle3_hit)
    );

    idle_timer #(.LIMIT(WAKE_IDLE_CYC)) u_idle5 (
        .clk_i(clk_i),
        .rst_i(sysrst),
        .run_i(line_j),
        .hit_o(idle5_hit)
    );

    idle_timer #(.LIMIT(`SE0_RESET_CYC)) u_se0 (
        .clk_i(clk_i),
        .rst_i(sysrst),
        .run_i(line_se0),
        .hit_o(se0_hit)
    );

    always_ff @(posedge clk_i)
    begin
        se0_hit_q <= sysrst ? 1'b0 : se0_hit;
    end

    assign se0_rise = se0_hit && !se0_hit_q;
    assign susp_enter = idle3_hit && !suspended_r;
    // Our own K must not be mistaken for host resume; a stopped clock sees no resume K, though SE0 bus reset still ends suspend.
    assign resume_det = suspended_r && line_k && wk_state_r != WK_DRIVE && osc_run_r;
    assign susp_exit = suspended_r && (resume_det || se0_rise);

    always_ff @(posedge clk_i)
    begin
        if (sysrst || susp_exit)
        begin
            suspended_r <= 1'b0;
        end
        else if (susp_enter)
        begin
            suspended_r <= 1'b1;
        end
    end

    assign suspend_o = suspended_r;

    // ------------------------------------------------------------------
    // Remote wakeup
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sysrst)
        begin
            wk_state_r <= WK_IDLE;
            drv_cnt_r <= '0;
        end
        else
        begin
            unique case (wk_state_r)
                WK_IDLE:
                begin
                    drv_cnt_r <= '0;
                    // Waiting on the 5 ms mark covers both early and late requests.
                    if (wake_req_r && suspended_r && idle5_hit && osc_run_r)
                    begin
                        wk_state_r <= WK_DRIVE;
                    end
                end
                WK_DRIVE:
                begin
                    drv_cnt_r <= drv_cnt_r + DRV_W'(1);
                    if (drv_cnt_r == DRV_W'(WAKE_DRIVE_CYC - 1))
                    begin
                        wk_state_r <= WK_SENT;
                    end
                end
                WK_SENT:
                begin
                    if (!suspended_r || susp_exit)
                    begin
                        wk_state_r <= WK_IDLE;
                    end
                end
                default:
                begin
                    wk_state_r <= WK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sysrst)
        begin
            d_oe_o <= 1'b0;
            dm_o <= 1'b0;
            dp_o <= 1'b0;
        end
        else
        begin
            d_oe_o <= (wk_state_r == WK_DRIVE) && drv_cnt_r != DRV_W'(WAKE_DRIVE_CYC - 1)
                || (wk_state_r == WK_IDLE && wake_req_r && suspended_r && idle5_hit
                && osc_run_r);
            dm_o <= (wk_state_r == WK_DRIVE) && drv_cnt_r != DRV_W'(WAKE_DRIVE_CYC - 1)
                || (wk_state_r == WK_IDLE && wake_req_r && suspended_r && idle5_hit
                && osc_run_r);
            dp_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sysrst)
        begin
            wake_req_r <= 1'b0;
        end
        else if (wk_state_r == WK_SENT && susp_exit)
        begin
            wake_req_r <= 1'b0;
        end
        else if (wr_en && wb_adr_i == `ADR_DEV_STATE)
        begin
            wake_req_r <= wbyte[`DEVST_WAKE_REQ];
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sysrst)
        begin
            mask_r <= `IRQ_MASK_RST;
        end
        else if (wr_en && wb_adr_i == `ADR_IRQ_MASK)
        begin
            mask_r <= wbyte;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sysrst)
        begin
            bus_rst_st_r <= 1'b0;
        end
        else if (se0_rise)
        begin
            bus_rst_st_r <= 1'b1;
        end
        else if (wr_en && wb_adr_i == `ADR_DEV_STATE && wbyte[`DEVST_BUS_RST])
        begin
            bus_rst_st_r <= 1'b0;
        end
    end

    // A set in the same cycle as a clear wins; disabled causes always read zero.
    always_comb
    begin
        flags_nxt = flags_r;
        if (wr_en && wb_adr_i == `ADR_IRQ_FLAGS)
        begin
            flags_nxt = flags_nxt & ~wbyte;
        end
        if (wr_en && wb_adr_i == `ADR_DEV_STATE && wbyte[`DEVST_BUS_RST])
        begin
            flags_nxt[`IRQ_BUS_RST] = 1'b0;
        end
        if (resume_det || se0_rise)
        begin
            flags_nxt[`IRQ_SUSP] = 1'b0;
        end
        flags_nxt = flags_nxt | ext_event_i & ~8'h60;
        flags_nxt[`IRQ_BUS_RST] = flags_nxt[`IRQ_BUS_RST] | se0_rise;
        flags_nxt[`IRQ_SUSP] = flags_nxt[`IRQ_SUSP] | susp_enter;
        flags_nxt = flags_nxt & mask_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (sysrst)
        begin
            flags_r <= 8'h00;
            irq_o <= 1'b0;
        end
        else
        begin
            flags_r <= flags_nxt;
            irq_o <= |flags_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = bus_req && wb_we_i && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];

    // One wait state; unmapped addresses answer with zero and drop writes.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req)
            begin
                unique case (wb_adr_i)
                    `ADR_SYS_CTRL: wb_dat_o <= {30'h0, !osc_run_r, 1'b0};
                    `ADR_DEV_STATE: wb_dat_o <= {25'h0, suspended_r, bus_rst_st_r,
                        wake_req_r, 3'h0, osc_run_r};
                    `ADR_IRQ_MASK: wb_dat_o <= {24'h0, mask_r};
                    `ADR_IRQ_FLAGS: wb_dat_o <= {24'h0, flags_r};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    soft_reset_take_a: assert property (
        wr_en && wb_adr_i == `ADR_SYS_CTRL && wbyte[0] |=> soft_rst_r ##1 mask_r == 8'h01)
        else $error("soft reset did not restore the enable mask");
    osc_restart_a: assert property (soft_rst_r |=> osc_run_r)
        else $error("oscillator not restarted by reset");
    mask_after_reset_a: assert property (
        $past(sysrst) |-> mask_r == 8'h01 && flags_r == 8'h00)
        else $error("reset left other enables or flags set");
    suspend_entry_a: assert property (
        susp_enter && mask_r[6] |=> suspended_r && flags_r[6] && irq_o)
        else $error("suspend entry missed its flag or interrupt");
    idle_restart_a: assert property (!line_j |=> !idle3_hit && !idle5_hit)
        else $error("idle counter survived bus activity");
    wake_gate_a: assert property (
        $rose(d_oe_o) |-> $past(suspended_r && idle5_hit && osc_run_r && wake_req_r))
        else $error("wakeup driven outside suspend or before 5 ms idle");
    wake_stopped_osc_a: assert property (!osc_run_r && !d_oe_o |=> !d_oe_o)
        else $error("wakeup started with the oscillator stopped");
    wake_clear_a: assert property (wk_state_r == WK_SENT && susp_exit |=> !wake_req_r)
        else $error("wakeup request not cleared on resume");
    bus_reset_flag_a: assert property (
        se0_rise |=> !flags_r[6] && (flags_r[5] == mask_r[5]) && bus_rst_st_r)
        else $error("bus reset did not update the cause flags");
    resume_blind_a: assert property (
        !osc_run_r && suspended_r && !se0_rise && !soft_rst_r |=> suspended_r)
        else $error("suspend left while the oscillator was stopped");
    irq_level_a: assert property (irq_o == (|flags_r))
        else $error("interrupt out of step with cause flags");

    wake_drive_c: cover property ($rose(d_oe_o));
    suspend_c: cover property ($rose(suspended_r));
    bus_reset_c: cover property (se0_rise ##1 flags_r[5]);
    soft_reset_c: cover property (soft_rst_r);

endmodule : usb_susp_ctrl

/* src/usb_susp_pkg.sv */
// Types shared by the suspend, reset and wakeup controller.
// Assumes nothing of its surroundings.
package usb_susp_pkg;

    typedef enum logic [1:0] {
        WK_IDLE = 2'b00,
        WK_DRIVE = 2'b01,
        WK_SENT = 2'b10
    } wake_state_t;

endpackage : usb_susp_pkg

/* verif/usb_host_model.sv */
// Host side of the downstream link: drives J, K or SE0 on command and answers
// a remote wakeup with resume K after a chosen gap.
// Assumes commands change just after a rising clock edge.
`timescale 1ns/1ps

module usb_host_model (
    input wire logic clk_i,
    input wire logic [1:0] cmd_i,
    input wire logic auto_i,
    input wire logic [3:0] gap_i,
    input wire logic dev_dp_i,
    input wire logic dev_dm_i,
    input wire logic dev_oe_i,
    output logic dp_o,
    output logic dm_o
);
    logic oe_r = 1'b0;
    logic [5:0] cnt_r = 6'h00;
    logic res_k;

    // A slow host waits gap_i clocks before its 30-clock resume K.
    always_ff @(posedge clk_i)
    begin
        oe_r <= dev_oe_i;
        if (oe_r && !dev_oe_i && auto_i)
            cnt_r <= 6'h1e + {2'h0, gap_i};
        else if (cnt_r != 6'h00)
            cnt_r <= cnt_r - 6'h01;
    end

    assign res_k = (cnt_r != 6'h00) && (cnt_r <= 6'h1e);

    // Released lines fall to J through the D+ pull-up and D- pull-down.
    always_comb
    begin
        if (dev_oe_i)
        begin
            dp_o = dev_dp_i;
            dm_o = dev_dm_i;
        end
        else if (res_k || cmd_i == 2'h1)
        begin
            dp_o = 1'b0;
            dm_o = 1'b1;
        end
        else if (cmd_i == 2'h2)
        begin
            dp_o = 1'b0;
            dm_o = 1'b0;
        end
        else
        begin
            dp_o = 1'b1;
            dm_o = 1'b0;
        end
    end
endmodule : usb_host_model

/* verif/usb_susp_ctrl_bench.sv */
// Self-checking bench for the suspend, reset and wakeup controller.
// Assumes the host model on the line side and short idle counts.
`timescale 1ns/1ps
`include "usb_susp_consts.svh"
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("Error at %0t: got %h exp %h", $time, g, e); \
        end \
    end

module usb_susp_ctrl_bench;
    localparam int SUSP = 20;
    localparam int WAKE = 40;
    localparam int DRV = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, dp_l, dm_l, dp_d, dm_d, oe;
    logic irq, susp, osc, srst, auto = 1'b1;
    logic [7:0] adr = 8'h00, ev = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [1:0] cmd = 2'h1;
    logic [3:0] gap = 4'h0;
    logic [3:0] sel = 4'h0;
    int failures = 0;
    int n_compared = 0;

    usb_susp_ctrl #(.SUSP_IDLE_CYC(SUSP), .WAKE_IDLE_CYC(WAKE), .WAKE_DRIVE_CYC(DRV))
    u_usb_susp_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .dp_i(dp_l), .dm_i(dm_l), .dp_o(dp_d), .dm_o(dm_d), .d_oe_o(oe), .ext_event_i(ev),
        .irq_o(irq), .suspend_o(susp), .osc_run_o(osc), .sys_rst_o(srst));

    usb_host_model u_usb_host_model (
        .clk_i(clk_i), .cmd_i(cmd), .auto_i(auto), .gap_i(gap), .dev_dp_i(dp_d),
        .dev_dm_i(dm_d), .dev_oe_i(oe), .dp_o(dp_l), .dm_o(dm_l));

    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    // --------------------------------
    // Bus and wait helpers
    // --------------------------------
    task automatic test_done;
    begin
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask : test_done

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // A missing answer ends the run; the slave is never waited on forever.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] q);
        int n;
    begin
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1)
        begin
            failures++;
            test_done();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        @(posedge clk_i);
    end
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hf, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
    begin
        wb(1'b0, a, 32'h0, 4'hf, q);
        `CHK(q, e)
    end
    endtask : rd

    // Waits for suspend_o (sel 0) or d_oe_o (sel 1) to reach v.
    task automatic waitv(input int sel, input logic v, input int lim);
        int n;
    begin
        for (n = 0; n < lim && (sel == 0 ? susp : oe) !== v; n++)
            @(posedge clk_i);
        if (n == lim)
        begin
            failures++;
            test_done();
        end
    end
    endtask : waitv

    task automatic go_suspend;
    begin
        @(posedge clk_i);
        cmd <= 2'h1;
        @(posedge clk_i);
        cmd <= 2'h0;
        tick(SUSP - 2);
        `CHK(susp, 1'b0)
        waitv(0, 1'b1, 8);
    end
    endtask : go_suspend

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_reset;
        logic [31:0] q;
    begin
        rd(`ADR_IRQ_MASK, 32'h01);
        rd(`ADR_DEV_STATE, 32'h01);
        wr(8'h10, 32'hff);
        rd(8'h10, 32'h0);
        wb(1'b1, `ADR_IRQ_MASK, 32'hff, 4'he, q);
        rd(`ADR_IRQ_MASK, 32'h01);
        @(posedge clk_i);
        ev <= 8'h01;
        @(posedge clk_i);
        ev <= 8'h00;
        tick(3);
        `CHK(irq, 1'b1)
        wr(`ADR_IRQ_FLAGS, 32'h01);
        tick(1);
        `CHK(irq, 1'b0)
    end
    endtask : t_reset

    task automatic t_suspend;
    begin
        wr(`ADR_IRQ_MASK, 32'h40);
        go_suspend();
        tick(2);
        `CHK(irq, 1'b1)
        rd(`ADR_IRQ_FLAGS, 32'h40);
        @(posedge clk_i);
        cmd <= 2'h1;
        tick(3);
        `CHK(susp, 1'b0)
        `CHK(irq, 1'b0)
        rd(`ADR_IRQ_FLAGS, 32'h0);
        go_suspend();
        wr(`ADR_IRQ_FLAGS, 32'h40);
        tick(1);
        `CHK(irq, 1'b0)
    end
    endtask : t_suspend

    task automatic t_busreset;
    begin
        wr(`ADR_IRQ_MASK, 32'h60);
        go_suspend();
        @(posedge clk_i);
        cmd <= 2'h2;
        tick(23);
        `CHK(susp, 1'b1)
        waitv(0, 1'b0, 6);
        @(posedge clk_i);
        cmd <= 2'h1;
        rd(`ADR_IRQ_FLAGS, 32'h20);
        wr(`ADR_IRQ_MASK, 32'h40);
        rd(`ADR_IRQ_FLAGS, 32'h0);
        `CHK(irq, 1'b0)
        wr(`ADR_DEV_STATE, 32'h20);
        rd(`ADR_DEV_STATE, 32'h01);
    end
    endtask : t_busreset

    task automatic t_wake_early;
        int n;
    begin
        wr(`ADR_DEV_STATE, 32'h10);
        tick(4);
        `CHK(oe, 1'b0)
        @(posedge clk_i);
        cmd <= 2'h0;
        tick(WAKE - 4);
        `CHK(oe, 1'b0)
        waitv(1, 1'b1, 8);
        `CHK({dp_d, dm_d}, 2'b01)
        for (n = 0; n < 20 && oe === 1'b1; n++)
            @(posedge clk_i);
        `CHK(n, DRV)
        waitv(0, 1'b0, 8);
        rd(`ADR_DEV_STATE, 32'h01);
        tick(30);
    end
    endtask : t_wake_early

    task automatic t_wake_late;
    begin
        @(posedge clk_i);
        gap <= 4'h5;
        go_suspend();
        tick(WAKE);
        wr(`ADR_DEV_STATE, 32'h10);
        waitv(1, 1'b1, 3);
        waitv(0, 1'b0, 30);
        tick(32);
    end
    endtask : t_wake_late

    task automatic t_osc_soft;
        int n;
    begin
        @(posedge clk_i);
        auto <= 1'b0;
        go_suspend();
        wr(`ADR_SYS_CTRL, 32'h02);
        tick(1);
        `CHK(osc, 1'b0)
        @(posedge clk_i);
        cmd <= 2'h1;
        tick(4);
        `CHK(susp, 1'b1)
        @(posedge clk_i);
        cmd <= 2'h0;
        wr(`ADR_DEV_STATE, 32'h10);
        n = 0;
        repeat (WAKE + 10)
        begin
            @(posedge clk_i);
            if (oe !== 1'b0)
                n++;
        end
        `CHK(n, 0)
        cmd <= 2'h1;
        wr(`ADR_SYS_CTRL, 32'h01);
        tick(2);
        `CHK({osc, susp, irq}, 3'b100)
        rd(`ADR_IRQ_MASK, 32'h01);
        rd(`ADR_DEV_STATE, 32'h01);
    end
    endtask : t_osc_soft

    task automatic t_hw_reset;
    begin
        wr(`ADR_IRQ_MASK, 32'h60);
        @(posedge clk_i);
        rst_i <= 1'b1;
        tick(3);
        `CHK(srst, 1'b1)
        rst_i <= 1'b0;
        tick(2);
        rd(`ADR_IRQ_MASK, 32'h01);
        `CHK(osc, 1'b1)
        `CHK(srst, 1'b0)
    end
    endtask : t_hw_reset

    initial
    begin
        tick(8);
        rst_i <= 1'b0;
        t_reset();
        t_suspend();
        t_busreset();
        t_wake_early();
        t_wake_late();
        t_osc_soft();
        t_hw_reset();
        test_done();
    end
endmodule : usb_susp_ctrl_bench
